// >>> design/port_cd_alt_pkg.sv
// Constants for the port C / port D alternate function override logic.
// Assumes a single core clock domain; used by the override module only.
package port_cd_alt_pkg;
	localparam int unsigned PORT_C_WIDTH      = 7;       // Port C pins 6..0
	localparam int unsigned PORT_D_WIDTH      = 8;       // Port D pins 7..0
	localparam int unsigned PC_SRC_BASE_C     = 8;       // Port C pin 0 is pin-change source 8
	localparam int unsigned PC_SRC_BASE_D     = 16;      // Port D pin 0 is pin-change source 16
	localparam int unsigned RESET_PIN_BIT     = 6;       // Reset/general pin of port C
	localparam int unsigned TW_CLOCK_BIT      = 5;       // Two-wire clock pin of port C
	localparam int unsigned TW_DATA_BIT       = 4;       // Two-wire data pin of port C
	localparam int unsigned TD0_CMP_A_BIT     = 6;       // Port D timer 0 compare A pin
	localparam int unsigned TD0_CMP_B_BIT     = 5;       // Port D timer 0 compare B pin
	localparam int unsigned TD2_CMP_B_BIT     = 3;       // Port D timer 2 compare B pin
	localparam int unsigned TD_T1_BIT         = 5;       // Timer 1 count input pin
	localparam int unsigned TD_T0_BIT         = 4;       // Timer 0 count input / USART clock pin
	localparam int unsigned TD_EXT_INTERRUPT_1_IN_BIT       = 3;       // External interrupt 1 pin
	localparam int unsigned TD_EXT_INTERRUPT_0_IN_BIT       = 2;       // External interrupt 0 pin
	localparam int unsigned TD_TXD_BIT        = 1;       // USART transmit pin
	localparam int unsigned TD_RXD_BIT        = 0;       // USART receive pin
	localparam int unsigned SPIKE_TIME_NS     = 50;      // Shortest spike passed by the filter
	localparam int unsigned CLK_PERIOD_NS     = 10;      // Core clock period
	// Least time rounds up to whole cycles; a zero time gives zero cycles
	localparam int unsigned SPIKE_CYCLES      = (SPIKE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam logic        RESET_PULLUP_VAL  = 1'b1;    // Pull-up value on reset pin override
	localparam logic        RESET_DIR_VAL     = 1'b0;    // Direction value on reset pin override
	localparam logic        TW_OUT_VAL        = 1'b0;    // Two-wire pins drive low only
	localparam logic [1:0]  SYNC_RESET        = 2'h3;    // Synchronisers idle high (bus released)
endpackage

// >>> design/port_cd_alt_override.sv
// Alternate function override logic for port C pins 6..0, plus pin routing of port D peripherals.
// Assumes the port core applies each override value where its enable is high, and
// that two-wire pad inputs arrive asynchronously to core_clk_i.
`timescale 1ns/1ps
`default_nettype none
module port_cd_alt_override
	import port_cd_alt_pkg::*;
#(
	parameter int unsigned FILTER_CYCLES = SPIKE_CYCLES     // Cycles an input must hold to pass
) (
	// Clock and reset
	input  wire logic                    core_clk_i,
	input  wire logic                    rstn_i,
	// Control inputs
	input  wire logic                    reset_pin_disable_fuse_i,
	input  wire logic                    two_wire_enable_i,
	input  wire logic                    global_pullup_disable_i,
	input  wire logic                    pin_change_group1_enable_i,
	input  wire logic                    pin_change_group2_enable_i,
	input  wire logic [PORT_C_WIDTH-1:0] pin_change_mask_c_i,        // Sources 14..8
	input  wire logic [PORT_D_WIDTH-1:0] pin_change_mask_d_i,        // Sources 23..16
	input  wire logic [5:0]              chan_digital_input_disable_i, // Channels 5..0
	input  wire logic [PORT_C_WIDTH-1:0] port_c_latch_i,             // Port C data register bits
	// Two-wire interface side
	input  wire logic                    two_wire_clock_out_i,
	input  wire logic                    two_wire_data_out_i,
	output logic                         two_wire_clock_in_o,
	output logic                         two_wire_data_in_o,
	// Port C pad inputs (asynchronous)
	input  wire logic [PORT_C_WIDTH-1:0] port_c_pad_i,
	// Port C override outputs
	output logic [PORT_C_WIDTH-1:0]      pullup_override_enable_o,
	output logic [PORT_C_WIDTH-1:0]      pullup_override_value_o,
	output logic [PORT_C_WIDTH-1:0]      direction_override_enable_o,
	output logic [PORT_C_WIDTH-1:0]      direction_override_value_o,
	output logic [PORT_C_WIDTH-1:0]      output_value_override_enable_o,
	output logic [PORT_C_WIDTH-1:0]      output_value_override_value_o,
	output logic [PORT_C_WIDTH-1:0]      input_enable_override_enable_o,
	output logic [PORT_C_WIDTH-1:0]      input_enable_override_value_o,
	// Pin-change source vector, bits 23..8
	input  wire logic [PORT_D_WIDTH-1:0] port_d_pin_i,               // Port D synchronised pin values
	output logic [23:8]                  pin_change_source_o,
	// Port D peripheral routing
	input  wire logic                    timer0_compare_a_out_i,
	input  wire logic                    timer0_compare_b_out_i,
	input  wire logic                    timer2_compare_b_out_i,
	input  wire logic                    usart_tx_i,
	output logic [PORT_D_WIDTH-1:0]      port_d_alt_out_o,           // Peripheral value per pin
	output logic                         timer0_count_input_o,
	output logic                         timer1_count_input_o,
	output logic                         usart_ext_clock_o,
	output logic                         ext_interrupt_0_in_o,
	output logic                         ext_interrupt_1_in_o,
	output logic                         usart_rx_o
);

	// Pin-change product for each port C pin (mask ANDed with group 1 enable).
	// Kept as one vector so the input-enable value and its enable share one term;
	// it is level based, so a mask change reaches the pad path in the same cycle.
	logic [PORT_C_WIDTH-1:0] pc_product; // One bit per port C pin
	assign pc_product = pin_change_mask_c_i & {PORT_C_WIDTH{pin_change_group1_enable_i}};

	// Per-pin override equations; each enable tells the port core to take the value
	// in place of its register setting
	always_comb begin
		pullup_override_enable_o       = '0;
		pullup_override_value_o        = '0;
		direction_override_enable_o    = '0;
		direction_override_value_o     = '0;
		output_value_override_enable_o = '0;
		output_value_override_value_o  = '0;
		// Low pins: analog disable or pin-change forces the input path
		for (int i = 0; i < 4; i++) begin
			input_enable_override_enable_o[i] = pc_product[i] | chan_digital_input_disable_i[i];
			input_enable_override_value_o[i]  = pc_product[i];
		end
		// Two-wire pins
		input_enable_override_enable_o[TW_CLOCK_BIT] = pc_product[TW_CLOCK_BIT]
			| chan_digital_input_disable_i[TW_CLOCK_BIT];
		input_enable_override_value_o[TW_CLOCK_BIT]  = pc_product[TW_CLOCK_BIT];
		input_enable_override_enable_o[TW_DATA_BIT]  = pc_product[TW_DATA_BIT]
			| chan_digital_input_disable_i[TW_DATA_BIT];
		input_enable_override_value_o[TW_DATA_BIT]   = pc_product[TW_DATA_BIT];
		if (two_wire_enable_i) begin
			// Interface owns both pins; pull-up still obeys the global disable
			pullup_override_enable_o[TW_CLOCK_BIT] = 1'b1;
			pullup_override_enable_o[TW_DATA_BIT]  = 1'b1;
			pullup_override_value_o[TW_CLOCK_BIT]  = port_c_latch_i[TW_CLOCK_BIT] & ~global_pullup_disable_i;
			pullup_override_value_o[TW_DATA_BIT]   = port_c_latch_i[TW_DATA_BIT] & ~global_pullup_disable_i;
			direction_override_enable_o[TW_CLOCK_BIT] = 1'b1;
			direction_override_enable_o[TW_DATA_BIT]  = 1'b1;
			direction_override_value_o[TW_CLOCK_BIT]  = two_wire_clock_out_i;
			direction_override_value_o[TW_DATA_BIT]   = two_wire_data_out_i;
			// Open drain: value fixed low, direction does the driving
			output_value_override_enable_o[TW_CLOCK_BIT] = 1'b1;
			output_value_override_enable_o[TW_DATA_BIT]  = 1'b1;
			output_value_override_value_o[TW_CLOCK_BIT]  = TW_OUT_VAL;
			output_value_override_value_o[TW_DATA_BIT]   = TW_OUT_VAL;
		end
		// Reset pin follows the fuse; output value never overridden
		pullup_override_enable_o[RESET_PIN_BIT]    = reset_pin_disable_fuse_i;
		pullup_override_value_o[RESET_PIN_BIT]     = RESET_PULLUP_VAL;
		direction_override_enable_o[RESET_PIN_BIT] = reset_pin_disable_fuse_i;
		direction_override_value_o[RESET_PIN_BIT]  = RESET_DIR_VAL;
		input_enable_override_enable_o[RESET_PIN_BIT] = reset_pin_disable_fuse_i | pc_product[RESET_PIN_BIT];
		input_enable_override_value_o[RESET_PIN_BIT]  = reset_pin_disable_fuse_i;
	end

	// Two-wire pad synchronisers; first stage feeds only the second.
	// Bit 1 carries the clock line and bit 0 the data line. Both reset high,
	// the released bus level, so no false falling edge follows reset.
	logic [1:0] clk_meta_q;
	logic [1:0] clk_sync_q;
	always_ff @(posedge core_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			clk_meta_q <= SYNC_RESET;
			clk_sync_q <= SYNC_RESET;
		end else begin
			clk_meta_q <= {port_c_pad_i[TW_CLOCK_BIT], port_c_pad_i[TW_DATA_BIT]};
			clk_sync_q <= clk_meta_q;
		end
	end

	// Spike filters: a new level passes only after holding FILTER_CYCLES cycles.
	// Trade-off: adds that much latency on every real edge.
	// A pulse shorter than the filter length clears the count and never passes.
	// Disabling the interface parks both outputs high, the idle bus level.
	localparam int unsigned CW = $clog2(FILTER_CYCLES + 1);
	logic [1:0]  filt_q;       // Filtered clock (1) and data (0)
	logic [CW-1:0] filt_cnt_q [2];
	for (genvar g = 0; g < 2; g++) begin : g_filter
		always_ff @(posedge core_clk_i or negedge rstn_i) begin
			if (!rstn_i) begin
				filt_q[g]     <= 1'b1;
				filt_cnt_q[g] <= '0;
			end else if (!two_wire_enable_i) begin
				// Filter idle while the interface is off
				filt_q[g]     <= 1'b1;
				filt_cnt_q[g] <= '0;
			end else if (clk_sync_q[g] == filt_q[g]) begin
				filt_cnt_q[g] <= '0;
			end else if (filt_cnt_q[g] == CW'(FILTER_CYCLES - 1)) begin
				filt_q[g]     <= clk_sync_q[g];
				filt_cnt_q[g] <= '0;
			end else begin
				filt_cnt_q[g] <= filt_cnt_q[g] + CW'(1);
			end
		end
	end
	assign two_wire_clock_in_o = filt_q[1];
	assign two_wire_data_in_o  = filt_q[0];

	// Port C pad synchronisers for pin-change sources.
	// A separate chain from the two-wire one; the two reset to different levels and may disagree
	// for two cycles after reset, which is harmless since they feed unrelated logic.
	logic [PORT_C_WIDTH-1:0] pc_meta_q;
	logic [PORT_C_WIDTH-1:0] pc_sync_q;
	always_ff @(posedge core_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			pc_meta_q <= '0;
			pc_sync_q <= '0;
		end else begin
			pc_meta_q <= port_c_pad_i;
			pc_sync_q <= pc_meta_q;
		end
	end

	// Source numbering: port C pins from 8, port D pins from 16; bit 15 unused
	always_comb begin
		pin_change_source_o = '0;
		for (int i = 0; i < PORT_C_WIDTH; i++) begin
			pin_change_source_o[PC_SRC_BASE_C + i] = pc_sync_q[i];
		end
		for (int i = 0; i < PORT_D_WIDTH; i++) begin
			pin_change_source_o[PC_SRC_BASE_D + i] = port_d_pin_i[i];
		end
	end

	// Port D peripheral output values, registered for clean pads.
	// Costs one cycle of latency on each peripheral output.
	always_ff @(posedge core_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			port_d_alt_out_o <= '0;
		end else begin
			port_d_alt_out_o                <= '0;
			port_d_alt_out_o[TD0_CMP_A_BIT] <= timer0_compare_a_out_i;
			port_d_alt_out_o[TD0_CMP_B_BIT] <= timer0_compare_b_out_i;
			port_d_alt_out_o[TD2_CMP_B_BIT] <= timer2_compare_b_out_i;
			port_d_alt_out_o[TD_TXD_BIT]    <= usart_tx_i;
		end
	end

	// Port D inputs to peripherals; pin 7 comparator use relies on software
	// These pin values are already synchronous to the core clock, so no flops here.
	assign timer1_count_input_o = port_d_pin_i[TD_T1_BIT];
	assign timer0_count_input_o = port_d_pin_i[TD_T0_BIT];
	assign usart_ext_clock_o    = port_d_pin_i[TD_T0_BIT];
	assign ext_interrupt_0_in_o = port_d_pin_i[TD_EXT_INTERRUPT_0_IN_BIT];
	assign ext_interrupt_1_in_o = port_d_pin_i[TD_EXT_INTERRUPT_1_IN_BIT];
	assign usart_rx_o           = port_d_pin_i[TD_RXD_BIT];

	// Group 2 enable kept for symmetry of the pin-change port set
	logic unused_group2;
	assign unused_group2 = pin_change_group2_enable_i & (|pin_change_mask_d_i);

endmodule
`default_nettype wire

// >>> verification/two_wire_bus_model.sv
// Far side of the two-wire pins: an open-drain bus with pull-ups.
// Assumes the design sinks a line only where its direction override drives high.
`timescale 1ns/1ps
`default_nettype none
module two_wire_bus_model (
	// Design side, clock then data
	input  wire logic [1:0] dir_en_i,
	input  wire logic [1:0] dir_val_i,
	// Remote device sinking a line
	input  wire logic [1:0] remote_low_i,
	// Resolved line levels
	output logic      [1:0] line_o
);
	// Pull-ups win unless a party sinks, so a released line never keeps a stale low
	assign line_o = ~((dir_en_i & dir_val_i) | remote_low_i);
endmodule
`default_nettype wire

// >>> verification/port_cd_alt_properties.sv
// Checker on the ports of the port C override block.
// Assumes the default filter length of at least three cycles.
`timescale 1ns/1ps
`default_nettype none
module port_cd_alt_properties (
	// Clock and reset
	input  wire logic        core_clk_i,
	input  wire logic        rstn_i,
	// Controls
	input  wire logic        reset_pin_disable_fuse_i,
	input  wire logic        two_wire_enable_i,
	input  wire logic        global_pullup_disable_i,
	input  wire logic        pin_change_group1_enable_i,
	input  wire logic        two_wire_clock_out_i,
	input  wire logic        two_wire_data_out_i,
	input  wire logic [6:0]  pin_change_mask_c_i,
	input  wire logic [6:0]  port_c_latch_i,
	input  wire logic [6:0]  port_c_pad_i,
	input  wire logic [5:0]  chan_digital_input_disable_i,
	// Observed outputs
	input  wire logic        two_wire_clock_in_o,
	input  wire logic [6:0]  pullup_override_enable_o,
	input  wire logic [6:0]  pullup_override_value_o,
	input  wire logic [6:0]  direction_override_enable_o,
	input  wire logic [6:0]  direction_override_value_o,
	input  wire logic [6:0]  output_value_override_enable_o,
	input  wire logic [6:0]  output_value_override_value_o,
	input  wire logic [6:0]  input_enable_override_enable_o,
	input  wire logic [6:0]  input_enable_override_value_o,
	input  wire logic [23:8] pin_change_source_o
);
	default clocking cb @(posedge core_clk_i); endclocking
	default disable iff (!rstn_i);
	wire [5:0] pc_hit = pin_change_mask_c_i[5:0] & {6{pin_change_group1_enable_i}}; // Masked-in sources
	// A one-cycle low spike on the clock line followed by a long high
	sequence s_spike;
		two_wire_clock_in_o && port_c_pad_i[5] ##1 !port_c_pad_i[5] ##1 port_c_pad_i[5] [*8];
	endsequence
	a_reset_pin_pull: assert property (
		pullup_override_enable_o[6] == reset_pin_disable_fuse_i && pullup_override_value_o[6]
		&& direction_override_enable_o[6] == reset_pin_disable_fuse_i && !direction_override_value_o[6]
		&& !output_value_override_enable_o[6]) else $error("reset pin override wrong");
	a_reset_pin_input: assert property (
		input_enable_override_enable_o[6] == (reset_pin_disable_fuse_i | (pin_change_mask_c_i[6]
		& pin_change_group1_enable_i)) && input_enable_override_value_o[6] == reset_pin_disable_fuse_i)
		else $error("reset pin input enable wrong");
	a_tw_pullup_gate: assert property (two_wire_enable_i |->
		pullup_override_value_o[5:4] == (port_c_latch_i[5:4] & ~{2{global_pullup_disable_i}}))
		else $error("two-wire pull-up wrong");
	a_tw_dir_out: assert property (two_wire_enable_i |-> direction_override_enable_o[5:4] == 2'h3
		&& direction_override_value_o[5:4] == {two_wire_clock_out_i, two_wire_data_out_i}
		&& output_value_override_enable_o[5:4] == 2'h3 && output_value_override_value_o[5:4] == 2'h0)
		else $error("two-wire direction wrong");
	a_low_pins_zero: assert property (
		{pullup_override_enable_o[3:0], direction_override_enable_o[3:0], output_value_override_enable_o[3:0]}
		== 12'h0) else $error("low pin override set");
	a_input_enable_eq: assert property (
		input_enable_override_enable_o[5:0] == (pc_hit | chan_digital_input_disable_i)
		&& input_enable_override_value_o[5:0] == pc_hit) else $error("input enable override wrong");
	a_filter_spike: assert property (s_spike |-> two_wire_clock_in_o)
		else $error("spike passed the filter");
	a_filter_hold: assert property ($fell(two_wire_clock_in_o) |->
		!$past(port_c_pad_i[5], 3) && !$past(port_c_pad_i[5], 4) && !$past(port_c_pad_i[5], 5))
		else $error("filter passed a short low");
	a_source_sync: assert property ($past(rstn_i, 2) |->
		pin_change_source_o[15:8] == {1'b0, $past(port_c_pad_i, 2)}) else $error("pin-change source wrong");
endmodule
bind port_cd_alt_override port_cd_alt_properties props_inst (
	.core_clk_i                     (core_clk_i),
	.rstn_i                         (rstn_i),
	.reset_pin_disable_fuse_i       (reset_pin_disable_fuse_i),
	.two_wire_enable_i              (two_wire_enable_i),
	.global_pullup_disable_i        (global_pullup_disable_i),
	.pin_change_group1_enable_i     (pin_change_group1_enable_i),
	.two_wire_clock_out_i           (two_wire_clock_out_i),
	.two_wire_data_out_i            (two_wire_data_out_i),
	.pin_change_mask_c_i            (pin_change_mask_c_i),
	.port_c_latch_i                 (port_c_latch_i),
	.port_c_pad_i                   (port_c_pad_i),
	.chan_digital_input_disable_i   (chan_digital_input_disable_i),
	.two_wire_clock_in_o            (two_wire_clock_in_o),
	.pullup_override_enable_o       (pullup_override_enable_o),
	.pullup_override_value_o        (pullup_override_value_o),
	.direction_override_enable_o    (direction_override_enable_o),
	.direction_override_value_o     (direction_override_value_o),
	.output_value_override_enable_o (output_value_override_enable_o),
	.output_value_override_value_o  (output_value_override_value_o),
	.input_enable_override_enable_o (input_enable_override_enable_o),
	.input_enable_override_value_o  (input_enable_override_value_o),
	.pin_change_source_o            (pin_change_source_o)
);
`default_nettype wire

// >>> verification/port_cd_alt_override_tb.sv
// Self-checking bench for the port C override block.
// Assumes a 100 MHz core clock and the default filter length.
`timescale 1ns/1ps
`default_nettype none
module port_cd_alt_override_tb;
	logic clk, rstn, fuse, twe, pu_off, g1, g2, sclo, sdao, cmp_a, cmp_b, cmp2_b, u_tx; // Stimulus
	logic [6:0] mc, latch, pads; // Masks, latches, other pads
	logic [7:0] md, pd;          // Port D masks and pins
	logic [5:0] dis;             // Digital input disables
	logic [1:0] far_low;         // Remote sinking the lines
	wire  [1:0] line;            // Resolved two-wire lines
	wire  sci, sdi, cnt0, cnt1, xclk, ext0, ext1, urx;
	wire  [6:0] pu_en, pu_val, dir_en, dir_val, ov_en, ov_val, ie_en, ie_val;
	wire  [23:8] src;
	wire  [7:0] dalt;
	int   num_errors = 0;
	int   n_compared = 0;
	port_cd_alt_override port_cd_alt_override_inst (.core_clk_i(clk), .rstn_i(rstn),
		.reset_pin_disable_fuse_i(fuse), .two_wire_enable_i(twe), .global_pullup_disable_i(pu_off),
		.pin_change_group1_enable_i(g1), .pin_change_group2_enable_i(g2), .pin_change_mask_c_i(mc),
		.pin_change_mask_d_i(md), .chan_digital_input_disable_i(dis), .port_c_latch_i(latch),
		.two_wire_clock_out_i(sclo), .two_wire_data_out_i(sdao), .two_wire_clock_in_o(sci),
		.two_wire_data_in_o(sdi), .port_c_pad_i({pads[6], line, pads[3:0]}), .pullup_override_enable_o(pu_en),
		.pullup_override_value_o(pu_val), .direction_override_enable_o(dir_en), .direction_override_value_o(dir_val),
		.output_value_override_enable_o(ov_en), .output_value_override_value_o(ov_val),
		.input_enable_override_enable_o(ie_en), .input_enable_override_value_o(ie_val), .port_d_pin_i(pd),
		.pin_change_source_o(src), .timer0_compare_a_out_i(cmp_a), .timer0_compare_b_out_i(cmp_b),
		.timer2_compare_b_out_i(cmp2_b), .usart_tx_i(u_tx), .port_d_alt_out_o(dalt), .timer0_count_input_o(cnt0),
		.timer1_count_input_o(cnt1), .usart_ext_clock_o(xclk), .ext_interrupt_0_in_o(ext0),
		.ext_interrupt_1_in_o(ext1), .usart_rx_o(urx));
	two_wire_bus_model two_wire_bus_model_inst (.dir_en_i(dir_en[5:4]), .dir_val_i(dir_val[5:4]),
		.remote_low_i(far_low), .line_o(line));
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		n_compared++;
		if (seen !== exp) begin
			num_errors++;
			$display("CHECK FAILED at %0t: got %h want %h", $time, seen, exp);
		end
	endtask
	task automatic conclude;
		if (num_errors == 0 && n_compared > 0) $display("Run complete: PASS");
		else $display("Run complete: FAIL");
		$finish;
	endtask
	task automatic t_reset_pin;
		for (int i = 0; i < 8; i++) begin
			@(negedge clk) {fuse, mc[6], g1} = i[2:0];
			#1;
			check({pu_en[6], dir_en[6], pu_val[6], dir_val[6], ov_en[6], ov_val[6]}, {fuse, fuse, 4'h8});
			check({ie_en[6], ie_val[6]}, {fuse | (mc[6] & g1), fuse});
		end
	endtask
	task automatic t_low_pins;
		for (int i = 0; i < 4; i++) begin
			@(negedge clk) g1 = i[0];
			mc[5:0] = i[1] ? 6'h2d : 6'h13;
			dis = i[1] ? 6'h06 : 6'h31;
			#1;
			check(ie_en[5:0], (mc[5:0] & {6{g1}}) | dis);
			check(ie_val[5:0], mc[5:0] & {6{g1}});
			check({pu_en[3:0], pu_val[3:0], dir_en[3:0], dir_val[3:0]}, 16'h0);
			check({ov_en[3:0], ov_val[3:0]}, 16'h0);
		end
	endtask
	task automatic t_two_wire;
		for (int i = 0; i < 16; i++) begin
			@(negedge clk) {twe, pu_off, latch[5:4]} = i[3:0];
			sclo = i[0];
			sdao = i[1] ^ i[2];
			#1;
			check({pu_en[5:4], dir_en[5:4], ov_en[5:4], ov_val[5:4]}, {{6{twe}}, 2'h0});
			if (twe) check({pu_val[5:4], dir_val[5:4]}, {latch[5:4] & ~{2{pu_off}}, sclo, sdao});
		end
		// Release both lines, then a one-cycle spike that the filter must eat
		@(negedge clk) {sclo, sdao} = 2'h0;
		repeat (12) @(negedge clk);
		far_low = 2'h2;
		@(negedge clk) far_low = 2'h0;
		repeat (10) @(negedge clk);
		check(sci, 1'b1);
		far_low = 2'h3;
		repeat (12) @(negedge clk);
		check({sci, sdi}, 2'h0);
		twe = 1'b0;
		repeat (3) @(negedge clk);
		check({sci, sdi}, 2'h3);
		far_low = 2'h0;
	endtask
	task automatic t_sources;
		for (int i = 0; i < 2; i++) begin
			@(negedge clk) pads = i[0] ? 7'h35 : 7'h4a;
			pd = i[0] ? 8'h69 : 8'h96;
			repeat (3) @(negedge clk);
			check(src[15:8], {1'b0, pads[6], 2'h3, pads[3:0]});
			check(src[23:16], pd);
		end
	endtask
	task automatic t_port_d;
		for (int i = 0; i < 2; i++) begin
			// Comparator pin stays a plain input with no pull-up asked
			@(negedge clk) {cmp_a, cmp_b, cmp2_b, u_tx} = i[0] ? 4'h4 : 4'hb;
			pd = i[0] ? 8'hc3 : 8'h3c;
			@(negedge clk);
			check(dalt, {1'b0, cmp_a, cmp_b, 1'b0, cmp2_b, 1'b0, u_tx, 1'b0});
			check({cnt1, cnt0, xclk, ext0, ext1, urx}, {pd[5], pd[4], pd[4], pd[2], pd[3], pd[0]});
		end
	endtask
	initial begin
		{rstn, fuse, twe, pu_off, g1, g2, sclo, sdao, cmp_a, cmp_b, cmp2_b, u_tx} = '0;
		{mc, latch, pads, md, pd, dis, far_low} = '0;
		repeat (12) @(negedge clk);
		rstn = 1'b1;
		t_reset_pin;
		t_low_pins;
		t_two_wire;
		t_sources;
		t_port_d;
		conclude;
	end
	// Watchdog: the whole sequence needs well under 200 cycles
	initial begin
		#20us;
		num_errors++;
		conclude;
	end
endmodule
`default_nettype wire
